// [src/spc_pkg.sv]
package spc_pkg;
    localparam int NPLL = 2;
    localparam int NBANK = 3;
    localparam int NCLK = 8;
    localparam int NIBUF = 16;
    localparam int AW = 5;
    localparam int DW = 32;
    localparam int CNT_W = 8;
    localparam int NSYNC = 5 + 2 * NPLL;

    localparam logic [AW-1:0] A_CTRL = 5'h00;
    localparam logic [AW-1:0] A_CFG = 5'h04;
    localparam logic [AW-1:0] A_IO = 5'h08;
    localparam logic [AW-1:0] A_CLK = 5'h0c;
    localparam logic [AW-1:0] A_IBG = 5'h10;
    localparam logic [AW-1:0] A_IBS = 5'h14;
    localparam logic [AW-1:0] A_STAT = 5'h18;

    localparam int CTRL_ENTER = 0;
    localparam int CTRL_EXIT = 1;
    localparam int IO_STBY_LSB = 8;

    typedef struct packed {
        logic [NPLL-1:0] pll_dis;
        logic osc_dis;
        logic pll_stby;
        logic osc_stby;
        logic por_off;
        logic bg_off;
    } spc_cfg_s;
    localparam int CFG_W = $bits(spc_cfg_s);

    localparam spc_cfg_s CFG_RST = '0;
    localparam logic [NCLK-1:0] CLK_RST = 8'hff;
    localparam logic [NBANK-1:0] IO_RST = 3'h0;
    localparam logic [NIBUF-1:0] IBUF_RST = 16'h0000;

    localparam int CLK_PERIOD_NS = 4;
    localparam int BG_SETTLE_NS = 1000;
    localparam int BG_SETTLE_CYC = (BG_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        ST_RUN = 3'h0,
        ST_PLL_WAIT = 3'h1,
        ST_STBY = 3'h3,
        ST_BG_UP = 3'h2,
        ST_ANA_UP = 3'h6
    } spc_state_e;
endpackage

// [src/spc_sync.sv]
`timescale 1ns/10ps
`default_nettype none
module spc_sync #(
    parameter int W = 1
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            meta_q <= '0;
            sync_q <= '0;
        end
        else
        begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;
endmodule
`default_nettype wire

// [src/spc_pll_ctl.sv]
`timescale 1ns/10ps
`default_nettype none
module spc_pll_ctl
    import spc_pkg::*;
(
    input wire logic clock,
    input wire logic resetn,
    input wire logic off_req,
    input wire logic out_low,
    input wire logic locked,
    output logic pwr_q,
    output logic out_en_q
);
    logic pwr_d;
    logic out_en_d;

    always_comb
    begin
        out_en_d = !off_req && pwr_q && locked;
        if (off_req)
            pwr_d = pwr_q && !(out_low && !out_en_q);
        else
            pwr_d = 1'b1;
    end

    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            pwr_q <= 1'b0;
            out_en_q <= 1'b0;
        end
        else
        begin
            pwr_q <= pwr_d;
            out_en_q <= out_en_d;
        end
    end

    a_pll_off_low: assert property (@(posedge clock) disable iff (!resetn)
        $fell(pwr_q) |-> $past(out_low) && !$past(out_en_q))
        else $error("pll powered off before its outputs were low");

    a_out_after_lock: assert property (@(posedge clock) disable iff (!resetn)
        $rose(out_en_q) |-> $past(locked) && $past(pwr_q))
        else $error("pll outputs enabled before lock");
endmodule
`default_nettype wire

// [src/spc_top.sv]
// Our own choices: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module spc_top
    import spc_pkg::*;
(
    input wire logic clock,
    input wire logic resetn,
    input wire logic [AW-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [DW-1:0] avs_writedata,
    output logic [DW-1:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic standby_pin,
    input wire logic cfg_enter,
    input wire logic cfg_exit,
    input wire logic vcc_low,
    input wire logic vcc_low_lp,
    input wire logic [NPLL-1:0] pll_out_low,
    input wire logic [NPLL-1:0] pll_locked,
    output logic bg_en,
    output logic por_en,
    output logic por_lp_en,
    output logic osc_en,
    output logic [NPLL-1:0] pll_pwr,
    output logic [NPLL-1:0] pll_out_en,
    output logic [NBANK-1:0] diff_off,
    output logic [NCLK-1:0] clk_en,
    output logic [NIBUF-1:0] ibuf_off,
    output logic reconfig,
    output logic standby
);
    function automatic logic hit(input logic [AW-1:0] addr, input logic [AW-1:0] a);
        hit = (addr == a);
    endfunction

    logic [NSYNC-1:0] sync_s;
    logic pin_s;
    logic enter_s;
    logic exit_s;
    logic vlow_s;
    logic vlp_s;
    logic [NPLL-1:0] olow_s;
    logic [NPLL-1:0] lock_s;
    logic [2:0] prev_q;
    logic want_q;
    logic want_d;
    spc_state_e state_q;
    spc_state_e state_d;
    logic [CNT_W-1:0] cnt_q;
    spc_cfg_s cfg_q;
    logic [NBANK-1:0] io_dyn_q;
    logic [NBANK-1:0] io_stby_q;
    logic [NCLK-1:0] clk_en_q;
    logic [NIBUF-1:0] ibg_q;
    logic [NIBUF-1:0] ibs_q;
    logic waitreq_q;
    logic [DW-1:0] rdata_q;
    logic bg_en_q;
    logic por_en_q;
    logic por_lp_en_q;
    logic osc_en_q;
    logic [NBANK-1:0] diff_off_q;
    logic [NIBUF-1:0] ibuf_off_q;
    logic reconfig_q;
    logic standby_q;
    logic [NPLL-1:0] pll_off;
    logic [NPLL-1:0] pll_pwr_w;
    logic [NPLL-1:0] pll_oen_w;
    logic wr_go;
    logic ana_off;
    logic pll_hold;
    logic all_down;
    logic all_up;

    spc_sync #(
        .W(NSYNC)
    ) u_sync (
        .clock(clock),
        .resetn(resetn),
        .async_in({standby_pin, cfg_enter, cfg_exit, vcc_low, vcc_low_lp, pll_out_low, pll_locked}),
        .sync_out(sync_s)
    );

    assign {pin_s, enter_s, exit_s, vlow_s, vlp_s, olow_s, lock_s} = sync_s;

    // request collection: set wins over clear
    always_comb
    begin
        want_d = want_q;
        if (pin_s != prev_q[2])
            want_d = !want_q;
        if ((exit_s && !prev_q[0]) || (wr_go && hit(avs_address, A_CTRL) && avs_writedata[CTRL_EXIT]))
            want_d = 1'b0;
        if ((enter_s && !prev_q[1]) || (wr_go && hit(avs_address, A_CTRL) && avs_writedata[CTRL_ENTER]))
            want_d = 1'b1;
    end

    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            prev_q <= 3'h0;
            want_q <= 1'b0;
        end
        else
        begin
            prev_q <= {pin_s, enter_s, exit_s};
            want_q <= want_d;
        end
    end

    // pll control, one per pll
    assign pll_hold = (state_q == ST_PLL_WAIT) || (state_q == ST_STBY) || (state_q == ST_BG_UP);

    generate
        for (genvar i = 0; i < NPLL; i++)
        begin : g_pll
            assign pll_off[i] = cfg_q.pll_dis[i] || (pll_hold && (cfg_q.pll_stby || cfg_q.bg_off));
            spc_pll_ctl u_pll (
                .clock(clock),
                .resetn(resetn),
                .off_req(pll_off[i]),
                .out_low(olow_s[i]),
                .locked(lock_s[i]),
                .pwr_q(pll_pwr_w[i]),
                .out_en_q(pll_oen_w[i])
            );
        end
    endgenerate

    assign all_down = &(~pll_off | ~pll_pwr_w);
    assign all_up = &(pll_off | pll_oen_w);

    // sequencer
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            ST_RUN:
                if (want_q)
                    state_d = ST_PLL_WAIT;
            ST_PLL_WAIT:
                if (all_down)
                    state_d = ST_STBY;
            ST_STBY:
                if (!want_q)
                    state_d = ST_BG_UP;
            ST_BG_UP:
                if (cnt_q == CNT_W'(BG_SETTLE_CYC - 1))
                    state_d = ST_ANA_UP;
            ST_ANA_UP:
                if (all_up)
                    state_d = ST_RUN;
            default:
                state_d = ST_RUN;
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (!resetn)
            state_q <= ST_RUN;
        else
            state_q <= state_d;
    end

    always_ff @(posedge clock)
    begin
        if (!resetn)
            cnt_q <= '0;
        else if (state_q == ST_BG_UP)
            cnt_q <= cnt_q + CNT_W'(1);
        else
            cnt_q <= '0;
    end

    // analog enables
    assign ana_off = (state_q == ST_STBY) || (state_q == ST_BG_UP);

    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            bg_en_q <= 1'b1;
            por_en_q <= 1'b1;
            por_lp_en_q <= 1'b1;
            osc_en_q <= 1'b1;
            diff_off_q <= IO_RST;
            standby_q <= 1'b0;
        end
        else
        begin
            bg_en_q <= !((state_q == ST_STBY) && cfg_q.bg_off);
            por_en_q <= !(ana_off && (cfg_q.por_off || cfg_q.bg_off));
            por_lp_en_q <= 1'b1;
            osc_en_q <= !cfg_q.osc_dis && !(ana_off && (cfg_q.osc_stby || cfg_q.bg_off));
            diff_off_q <= io_dyn_q | (ana_off ? (io_stby_q | {NBANK{cfg_q.bg_off}}) : '0);
            standby_q <= state_q == ST_STBY;
        end
    end

    // supply monitors
    always_ff @(posedge clock)
    begin
        if (!resetn)
            reconfig_q <= 1'b0;
        else
            reconfig_q <= (por_en_q && vlow_s) || (!por_en_q && vlp_s);
    end

    // clock nets and input buffers stay under software control in standby
    always_ff @(posedge clock)
    begin
        if (!resetn)
            ibuf_off_q <= IBUF_RST;
        else
            ibuf_off_q <= ibg_q | (standby_q ? ibs_q : '0);
    end

    // avalon slave: one wait cycle, then answer
    assign wr_go = avs_write && !waitreq_q;

    always_ff @(posedge clock)
    begin
        if (!resetn)
            waitreq_q <= 1'b1;
        else
            waitreq_q <= !((avs_read || avs_write) && waitreq_q);
    end

    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            cfg_q <= CFG_RST;
            io_dyn_q <= IO_RST;
            io_stby_q <= IO_RST;
            clk_en_q <= CLK_RST;
            ibg_q <= IBUF_RST;
            ibs_q <= IBUF_RST;
        end
        else if (wr_go)
        begin
            if (hit(avs_address, A_CFG))
                cfg_q <= avs_writedata[CFG_W-1:0];
            if (hit(avs_address, A_IO))
            begin
                io_dyn_q <= avs_writedata[NBANK-1:0];
                io_stby_q <= avs_writedata[IO_STBY_LSB +: NBANK];
            end
            if (hit(avs_address, A_CLK))
                clk_en_q <= avs_writedata[NCLK-1:0];
            if (hit(avs_address, A_IBG))
                ibg_q <= avs_writedata[NIBUF-1:0];
            if (hit(avs_address, A_IBS))
                ibs_q <= avs_writedata[NIBUF-1:0];
        end
    end

    always_ff @(posedge clock)
    begin
        if (!resetn)
            rdata_q <= '0;
        else if (avs_read && waitreq_q)
        begin
            case (avs_address)
                A_CTRL: rdata_q <= DW'(want_q);
                A_CFG: rdata_q <= DW'(cfg_q);
                A_IO: rdata_q <= DW'({io_stby_q, 5'h00, io_dyn_q});
                A_CLK: rdata_q <= DW'(clk_en_q);
                A_IBG: rdata_q <= DW'(ibg_q);
                A_IBS: rdata_q <= DW'(ibs_q);
                A_STAT: rdata_q <= DW'({pll_oen_w, pll_pwr_w, osc_en_q, por_en_q, bg_en_q, standby_q, state_q});
                default: rdata_q <= '0;
            endcase
        end
    end

    assign avs_readdata = rdata_q;
    assign avs_waitrequest = waitreq_q;
    assign bg_en = bg_en_q;
    assign por_en = por_en_q;
    assign por_lp_en = por_lp_en_q;
    assign osc_en = osc_en_q;
    assign pll_pwr = pll_pwr_w;
    assign pll_out_en = pll_oen_w;
    assign diff_off = diff_off_q;
    assign clk_en = clk_en_q;
    assign ibuf_off = ibuf_off_q;
    assign reconfig = reconfig_q;
    assign standby = standby_q;

    sequence s_leave;
        state_q == ST_STBY ##1 state_q == ST_BG_UP;
    endsequence

    sequence s_enter;
        state_q == ST_RUN && want_q ##1 state_q == ST_PLL_WAIT;
    endsequence

    a_enter_req: assert property (@(posedge clock) disable iff (!resetn)
        state_q == ST_RUN && want_q |-> s_enter)
        else $error("standby request not taken");

    a_bg_forces_off: assert property (@(posedge clock) disable iff (!resetn)
        state_q == ST_STBY && cfg_q.bg_off |=> !bg_en_q && !por_en_q && !osc_en_q && (&diff_off_q))
        else $error("band gap off left dependent circuits on");

    a_por_reconfig: assert property (@(posedge clock) disable iff (!resetn)
        por_en_q && vlow_s |=> reconfig_q)
        else $error("supply drop did not trigger reconfiguration");

    a_lp_detect: assert property (@(posedge clock) disable iff (!resetn)
        !por_en_q && vlp_s |=> reconfig_q)
        else $error("reduced detector ignored while monitor off");

    a_osc_static: assert property (@(posedge clock) disable iff (!resetn)
        cfg_q.osc_dis |=> !osc_en_q)
        else $error("oscillator on while disabled");

    a_clk_net_wr: assert property (@(posedge clock) disable iff (!resetn)
        wr_go && avs_address == A_CLK |=> clk_en_q == $past(avs_writedata[NCLK-1:0]))
        else $error("clock net enable not updated");

    a_ibuf_stby: assert property (@(posedge clock) disable iff (!resetn)
        standby_q |=> ibuf_off_q == ($past(ibg_q) | $past(ibs_q)))
        else $error("standby input gating wrong");

    a_bg_first: assert property (@(posedge clock) disable iff (!resetn)
        s_leave |-> ##1 bg_en_q && ((pll_oen_w & pll_off) == '0))
        else $error("band gap not first on exit");

    a_wait_one: assert property (@(posedge clock) disable iff (!resetn)
        (avs_read || avs_write) && waitreq_q |=> !waitreq_q ##1 waitreq_q)
        else $error("waitrequest not a single low cycle");
endmodule
`default_nettype wire

// [dv/spc_pll_model.sv]
`timescale 1ns/10ps
`default_nettype none
// far-side pll pair: lock after power-up, outputs go low some cycles after gating
module spc_pll_model
    import spc_pkg::*;
#(
    parameter int LOCK_DLY = 12
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic slow,
    input wire logic [NPLL-1:0] pll_pwr,
    input wire logic [NPLL-1:0] pll_out_en,
    output logic [NPLL-1:0] pll_out_low,
    output logic [NPLL-1:0] pll_locked
);
    logic [7:0] lock_cnt_q [NPLL];
    logic [7:0] low_cnt_q [NPLL];
    always_ff @(posedge clock)
    begin
        for (int i = 0; i < NPLL; i++)
        begin
            if (!resetn || !pll_pwr[i])
            begin
                lock_cnt_q[i] <= 8'h00;
                pll_locked[i] <= 1'b0;
            end
            else if (lock_cnt_q[i] == 8'(LOCK_DLY))
                pll_locked[i] <= 1'b1;
            else
                lock_cnt_q[i] <= lock_cnt_q[i] + 8'h01;
            if (!resetn || (pll_out_en[i] && pll_pwr[i]))
            begin
                low_cnt_q[i] <= 8'h00;
                pll_out_low[i] <= !resetn;
            end
            else if (!pll_pwr[i] || low_cnt_q[i] == (slow ? 8'h14 : 8'h01))
                pll_out_low[i] <= 1'b1;
            else
                low_cnt_q[i] <= low_cnt_q[i] + 8'h01;
        end
    end
endmodule
`default_nettype wire

// [dv/standby_power_saving_control_test.sv]
`timescale 1ns/10ps
`default_nettype none
module standby_power_saving_control_test
    import spc_pkg::*;
;
    logic clock, resetn, avs_read, avs_write, avs_waitrequest, standby_pin, cfg_enter, cfg_exit;
    logic vcc_low, vcc_low_lp, bg_en, por_en, por_lp_en, osc_en, reconfig, standby, slow;
    logic [AW-1:0] avs_address;
    logic [DW-1:0] avs_writedata, avs_readdata, rnd, exp_rd;
    logic [NPLL-1:0] pll_out_low, pll_locked, pll_pwr, pll_out_en, p_pwr, p_oen, p_low, p_lock;
    logic [NBANK-1:0] diff_off;
    logic [NCLK-1:0] clk_en, clk_v;
    logic [NIBUF-1:0] ibuf_off, ibg_v;
    logic [DW-1:0] rd_q [$];
    int failures = 0, tests_run = 0, cyc = 0, n;
    spc_top i_spc_top (.clock(clock), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .standby_pin(standby_pin), .cfg_enter(cfg_enter),
        .cfg_exit(cfg_exit), .vcc_low(vcc_low), .vcc_low_lp(vcc_low_lp), .pll_out_low(pll_out_low),
        .pll_locked(pll_locked), .bg_en(bg_en), .por_en(por_en), .por_lp_en(por_lp_en), .osc_en(osc_en),
        .pll_pwr(pll_pwr), .pll_out_en(pll_out_en), .diff_off(diff_off), .clk_en(clk_en),
        .ibuf_off(ibuf_off), .reconfig(reconfig), .standby(standby));
    spc_pll_model i_spc_pll_model (.clock(clock), .resetn(resetn), .slow(slow), .pll_pwr(pll_pwr),
        .pll_out_en(pll_out_en), .pll_out_low(pll_out_low), .pll_locked(pll_locked));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    begin
        tests_run++;
        if (seen !== exp)
        begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    end
    endtask
    task print_verdict;
    begin
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    end
    endtask
    task bus_write(input logic [AW-1:0] a, input logic [DW-1:0] d);
    begin
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= 1'b1;
        @(posedge clock);
        while (avs_waitrequest !== 1'b0) @(posedge clock);
        avs_write <= 1'b0;
        @(posedge clock);
    end
    endtask
    task bus_read(input logic [AW-1:0] a, input logic [DW-1:0] e);
    begin
        rd_q.push_back(e);
        avs_address <= a;
        avs_read <= 1'b1;
        @(posedge clock);
        while (avs_waitrequest !== 1'b0) @(posedge clock);
        avs_read <= 1'b0;
        @(posedge clock);
    end
    endtask
    task wait_up;
    begin
        for (n = 0; n < 2000 && pll_out_en !== 2'h3; n++) @(posedge clock);
    end
    endtask
    initial
    begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    // read answers pop the oldest expectation
    always @(posedge clock)
    begin
        cyc++;
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && rd_q.size() > 0)
        begin
            exp_rd = rd_q.pop_front();
            check("readdata", avs_readdata, exp_rd);
        end
        if (resetn === 1'b1)
            for (int i = 0; i < NPLL; i++)
            begin
                if (p_pwr[i] && !pll_pwr[i])
                    check("pll_off_gate", {p_oen[i], p_low[i]}, 2'b01);
                if (!p_oen[i] && pll_out_en[i])
                    check("pll_oen_lock", p_lock[i], 1'b1);
                if (!p_pwr[i] && pll_pwr[i])
                    check("pll_after_bg", bg_en, 1'b1);
            end
        p_pwr <= pll_pwr;
        p_oen <= pll_out_en;
        p_low <= pll_out_low;
        p_lock <= pll_locked;
        if (cyc == 30000)
        begin
            failures++;
            print_verdict;
        end
    end
    initial
    begin
        {resetn, avs_read, avs_write, standby_pin, cfg_enter, cfg_exit, vcc_low, vcc_low_lp, slow} <= '0;
        avs_address <= '0;
        avs_writedata <= '0;
        rnd = 32'h5853f598;
        repeat (5) @(posedge clock);
        resetn <= 1'b1;
        wait_up;
        check("rst_outs", {bg_en, por_en, por_lp_en, osc_en, diff_off, clk_en, ibuf_off, standby}, 32'hf1fe0000);
        bus_read(A_CFG, 32'h0);
        bus_read(5'h1c, 32'h0);
        rnd = lfsr(rnd);
        bus_write(A_CLK, rnd);
        bus_read(A_CLK, {24'h0, rnd[7:0]});
        check("clk_en", clk_en, rnd[7:0]);
        clk_v = rnd[7:0];
        rnd = lfsr(rnd);
        ibg_v = rnd[15:0];
        bus_write(A_IBG, rnd);
        bus_write(A_IO, 32'h0000_0205);
        @(posedge clock);
        check("ibuf_off", ibuf_off, ibg_v);
        check("diff_off", diff_off, 3'h5);
        vcc_low <= 1'b1;
        repeat (6) @(posedge clock);
        check("reconfig_main", reconfig, 1'b1);
        vcc_low <= 1'b0;
        repeat (6) @(posedge clock);
        check("reconfig_clear", reconfig, 1'b0);
        // band gap off: every analog piece except the reduced detector (por_lp_en) follows it down
        bus_write(A_IBS, 32'h0000_00f0);
        bus_write(A_CFG, 32'h1);
        bus_write(A_CTRL, 32'h1);
        for (n = 0; n < 300 && standby !== 1'b1; n++) @(posedge clock);
        repeat (2) @(posedge clock);
        check("stby_bg", {bg_en, por_en, osc_en, por_lp_en, pll_pwr, diff_off}, 9'h027);
        check("stby_ibuf", ibuf_off, ibg_v | 16'h00f0);
        check("stby_clk", clk_en, clk_v);
        bus_read(A_CTRL, 32'h1);
        cfg_exit <= 1'b1;
        for (n = 0; n < 100 && standby !== 1'b0; n++) @(posedge clock);
        cfg_exit <= 1'b0;
        for (n = 0; n < 400 && por_en !== 1'b1; n++) @(posedge clock);
        check("bg_settle", 32'(n >= 245 && n < 400), 32'h1);
        wait_up;
        // monitor off with reliable supplies, oscillator off in standby
        bus_write(A_CFG, 32'h6);
        standby_pin <= 1'b1;
        for (n = 0; n < 300 && standby !== 1'b1; n++) @(posedge clock);
        repeat (2) @(posedge clock);
        check("stby_por", {bg_en, por_en, osc_en, por_lp_en, pll_pwr, diff_off}, 9'h13f);
        vcc_low_lp <= 1'b1;
        repeat (6) @(posedge clock);
        check("reconfig_lp", reconfig, 1'b1);
        vcc_low_lp <= 1'b0;
        repeat (6) @(posedge clock);
        standby_pin <= 1'b0;
        for (n = 0; n < 600 && por_en !== 1'b1; n++) @(posedge clock);
        check("pin_exit", {standby, por_en, osc_en}, 3'h3);
        wait_up;
        // slow pll outputs: power must wait for them
        slow <= 1'b1;
        bus_write(A_CFG, 32'h8);
        cfg_enter <= 1'b1;
        for (n = 0; n < 100 && pll_out_en !== 2'h0; n++) @(posedge clock);
        repeat (3) @(posedge clock);
        check("pll_hold", pll_pwr, 2'h3);
        for (n = 0; n < 300 && standby !== 1'b1; n++) @(posedge clock);
        repeat (2) @(posedge clock);
        check("stby_pll", {pll_pwr, bg_en}, 3'h1);
        cfg_enter <= 1'b0;
        bus_write(A_CTRL, 32'h2);
        for (n = 0; n < 100 && standby !== 1'b0; n++) @(posedge clock);
        check("ctrl_exit", standby, 1'b0);
        slow <= 1'b0;
        wait_up;
        bus_write(A_CFG, 32'h50);
        repeat (12) @(posedge clock);
        check("static_dis", {osc_en, pll_pwr}, 3'h1);
        bus_read(A_CFG, 32'h50);
        print_verdict;
    end
endmodule
`default_nettype wire
